// *** core/scsi_seq_pkg.sv ***
package scsi_seq_pkg;

	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_INTERRUPT_CAUSE = 8'h05;
	localparam logic [7:0] IDX_SEQUENCE_STEP = 8'h06;
	localparam logic [7:0] IDX_SEQ_CONTROL = 8'h0B;
	localparam logic [11:0] ADDR_INTERRUPT_CAUSE = {2'h0, IDX_INTERRUPT_CAUSE, 2'h0};
	localparam logic [11:0] ADDR_SEQUENCE_STEP = {2'h0, IDX_SEQUENCE_STEP, 2'h0};
	localparam logic [11:0] ADDR_SEQ_CONTROL = {2'h0, IDX_SEQ_CONTROL, 2'h0};

	// control field position and reset values
	localparam int CTRL_EXT_MSG_BIT = 0;
	localparam logic RESET_EXT_MSG = 1'b0;
	localparam logic [7:0] RESET_CAUSE = 8'h00;
	localparam logic [2:0] RESET_STEP = 3'h0;

	// interrupt cause bits
	localparam logic [7:0] CAUSE_SELECTED = 8'h01;
	localparam logic [7:0] CAUSE_SEL_ATN = 8'h02;
	localparam logic [7:0] CAUSE_FUNC_DONE = 8'h08;
	localparam logic [7:0] CAUSE_BUS_SERVICE = 8'h10;
	localparam logic [7:0] CAUSE_DISCONNECT = 8'h20;

	// step codes
	localparam logic [2:0] STEP_0 = 3'h0;
	localparam logic [2:0] STEP_1 = 3'h1;
	localparam logic [2:0] STEP_2 = 3'h2;
	localparam logic [2:0] STEP_4 = 3'h4;
	localparam logic [2:0] STEP_5 = 3'h5;
	localparam logic [2:0] STEP_6 = 3'h6;

	localparam logic [7:0] NULL_MESSAGE = 8'h00;
	localparam logic [1:0] MSG_ONE = 2'h1;
	localparam logic [1:0] MSG_TWO = 2'h2;

	typedef enum logic [2:0] {
		SEQ_SEL_PLAIN = 3'h0,
		SEQ_SEL_ATN = 3'h1,
		SEQ_RECV_CMD = 3'h2,
		SEQ_DISCONNECT = 3'h3,
		SEQ_TERMINATE = 3'h4
	} seq_kind_e;

	typedef enum logic [2:0] {
		OUT_DONE = 3'h0,
		OUT_PARITY_CMD = 3'h1,
		OUT_PARITY_MSG = 3'h2,
		OUT_BAD_ID = 3'h3,
		OUT_ATN_HOLD = 3'h4,
		OUT_ATN_STOP = 3'h5,
		OUT_HALT_SEL = 3'h6
	} outcome_e;

	typedef enum logic [1:0] {
		FILL_IDLE = 2'b00,
		FILL_ID = 2'b01,
		FILL_NULL = 2'b11
	} fill_state_e;

	// end-of-sequence report from the sequencer
	typedef struct packed {
		logic valid;
		seq_kind_e kind;
		outcome_e outcome;
		logic [1:0] bytes_done;
		logic [7:0] bus_id;
	} seq_report_s;

	typedef struct packed {
		logic [2:0] step;
		logic [7:0] cause;
	} seq_result_s;

endpackage

// *** core/scsi_target_sequence_status.sv ***
`timescale 1ns/1ns
module scsi_target_sequence_status
	import scsi_seq_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// scsi pin, active low
	input wire logic scsi_atn_n,
	// sequencer side
	input wire logic seq_start,
	input wire logic cmd_phase,
	input wire seq_report_s report,
	// fifo load and status
	output logic fifo_push,
	output logic [7:0] fifo_data,
	output logic report_done,
	output logic extended_message_mode
);

	logic [7:0] interrupt_cause;
	logic [2:0] sequence_step;
	logic atn_meta;
	logic atn_sync;
	logic atn_in_cmd;
	logic atn_flag;
	logic [7:0] held_id;
	fill_state_e fill_state;
	seq_result_s next_result;

	// 0 none, 1 cause, 2 step, 3 control
	function automatic logic [1:0] reg_sel(input logic [11:0] addr);
		logic [1:0] sel;
		sel = 2'h0;
		case (addr)
			ADDR_INTERRUPT_CAUSE: sel = 2'h1;
			ADDR_SEQUENCE_STEP: sel = 2'h2;
			ADDR_SEQ_CONTROL: sel = 2'h3;
			default: sel = 2'h0;
		endcase
		return sel;
	endfunction

	function automatic seq_result_s encode(input seq_report_s r,
		input logic ext, input logic atn);
		seq_result_s res;
		logic [7:0] svc;
		res.step = STEP_0;
		res.cause = RESET_CAUSE;
		svc = atn ? CAUSE_BUS_SERVICE : 8'h00;
		case (r.kind)
			SEQ_SEL_PLAIN:
			begin
				res.cause = CAUSE_SELECTED | svc;
				case (r.outcome)
					OUT_DONE: res.step = STEP_2;
					OUT_PARITY_CMD: res.step = STEP_1;
					default:
					begin
						res.step = STEP_0;
						res.cause = CAUSE_SELECTED;
					end
				endcase
			end
			SEQ_SEL_ATN:
			begin
				res.cause = CAUSE_SEL_ATN | svc;
				case (r.outcome)
					OUT_DONE:
						res.step = (ext && r.bytes_done != MSG_ONE) ?
							STEP_6 : STEP_2;
					OUT_PARITY_CMD:
						res.step = (ext && r.bytes_done != MSG_ONE) ?
							STEP_5 : STEP_1;
					OUT_ATN_HOLD:
					begin
						res.step = ext ? STEP_4 : STEP_0;
						res.cause = CAUSE_SEL_ATN | CAUSE_BUS_SERVICE;
					end
					OUT_PARITY_MSG:
					begin
						if (ext && r.bytes_done >= MSG_TWO)
						begin
							res.step = STEP_4;
							res.cause = CAUSE_SEL_ATN;
						end
						else
							res.step = STEP_0;
					end
					default: res.step = STEP_0;
				endcase
			end
			SEQ_RECV_CMD:
			begin
				res.cause = CAUSE_FUNC_DONE | svc;
				res.step = (r.outcome == OUT_DONE) ? STEP_2 : STEP_1;
			end
			default:
			begin
				if (r.outcome == OUT_DONE)
				begin
					res.step = STEP_2;
					res.cause = CAUSE_DISCONNECT | CAUSE_FUNC_DONE;
				end
				else
				begin
					res.step = (r.bytes_done >= MSG_TWO) ? STEP_1 : STEP_0;
					res.cause = CAUSE_BUS_SERVICE | CAUSE_FUNC_DONE;
				end
			end
		endcase
		return res;
	endfunction

	// atn pin synchroniser
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			atn_meta <= 1'b0;
			atn_sync <= 1'b0;
		end
		else
		begin
			atn_meta <= !scsi_atn_n;
			atn_sync <= atn_meta;
		end
	end

	// atn seen in command phase; set wins over clear
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			atn_in_cmd <= 1'b0;
		else if (atn_sync && cmd_phase)
			atn_in_cmd <= 1'b1;
		else if (seq_start)
			atn_in_cmd <= 1'b0;
	end

	assign atn_flag = atn_in_cmd || atn_sync;
	assign next_result = encode(report, extended_message_mode, atn_flag);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sequence_step <= RESET_STEP;
			interrupt_cause <= RESET_CAUSE;
			report_done <= 1'b0;
		end
		else
		begin
			report_done <= report.valid;
			if (report.valid)
			begin
				sequence_step <= next_result.step;
				interrupt_cause <= next_result.cause;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			fill_state <= FILL_IDLE;
			held_id <= 8'h00;
			fifo_push <= 1'b0;
			fifo_data <= 8'h00;
		end
		else
		begin
			fifo_push <= 1'b0;
			case (fill_state)
				FILL_IDLE:
				begin
					if (report.valid && report.kind == SEQ_SEL_PLAIN &&
						report.outcome == OUT_HALT_SEL)
					begin
						held_id <= report.bus_id;
						fill_state <= FILL_ID;
					end
				end
				FILL_ID:
				begin
					fifo_push <= 1'b1;
					fifo_data <= held_id;
					fill_state <= FILL_NULL;
				end
				FILL_NULL:
				begin
					fifo_push <= 1'b1;
					fifo_data <= NULL_MESSAGE;
					fill_state <= FILL_IDLE;
				end
				default: fill_state <= FILL_IDLE;
			endcase
		end
	end

	// control register write
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			extended_message_mode <= RESET_EXT_MSG;
		else if (psel && penable && pwrite && reg_sel(paddr) == 2'h3)
			extended_message_mode <= pwdata[CTRL_EXT_MSG_BIT];
	end

	// read data captured in setup phase
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata <= 32'h00000000;
			pslverr <= 1'b0;
		end
		else if (psel && !penable)
		begin
			pslverr <= (reg_sel(paddr) == 2'h0);
			case (reg_sel(paddr))
				2'h1: prdata <= {24'h000000, interrupt_cause};
				2'h2: prdata <= {29'h0, sequence_step};
				2'h3: prdata <= {31'h0, extended_message_mode};
				default: prdata <= 32'h00000000;
			endcase
		end
	end

	assign pready = 1'b1;

	sequence s_plain_done;
		report.valid && report.kind == SEQ_SEL_PLAIN &&
			report.outcome == OUT_DONE;
	endsequence

	property p_plain_done;
		@(posedge pclk) disable iff (!presetn)
		s_plain_done |=> sequence_step == STEP_2 &&
			interrupt_cause == (CAUSE_SELECTED |
			($past(atn_flag) ? CAUSE_BUS_SERVICE : 8'h00));
	endproperty
	a_plain_done: assert property (p_plain_done)
		else $error("plain select completion code wrong");

	property p_plain_parity;
		@(posedge pclk) disable iff (!presetn)
		(report.valid && report.kind == SEQ_SEL_PLAIN &&
			report.outcome == OUT_PARITY_CMD && atn_flag) |=>
			sequence_step == STEP_1 && interrupt_cause == 8'h11;
	endproperty
	a_plain_parity: assert property (p_plain_parity)
		else $error("plain select parity with atn code wrong");

	sequence s_fill;
		fill_state == FILL_ID ##1 fifo_push && fifo_data == held_id
			##1 fifo_push && fifo_data == NULL_MESSAGE;
	endsequence

	property p_fill;
		@(posedge pclk) disable iff (!presetn)
		(report.valid && report.kind == SEQ_SEL_PLAIN &&
			report.outcome == OUT_HALT_SEL && fill_state == FILL_IDLE)
			|=> s_fill;
	endproperty
	a_fill: assert property (p_fill)
		else $error("bus id and null byte not loaded");

	property p_plain_halt;
		@(posedge pclk) disable iff (!presetn)
		(report.valid && report.kind == SEQ_SEL_PLAIN &&
			report.outcome == OUT_HALT_SEL) |=>
			sequence_step == STEP_0 && interrupt_cause == CAUSE_SELECTED;
	endproperty
	a_plain_halt: assert property (p_plain_halt)
		else $error("plain select halt code wrong");

	property p_atn_hold;
		@(posedge pclk) disable iff (!presetn)
		(report.valid && report.kind == SEQ_SEL_ATN &&
			report.outcome == OUT_ATN_HOLD) |=>
			interrupt_cause == 8'h12 && sequence_step ==
			($past(extended_message_mode) ? STEP_4 : STEP_0);
	endproperty
	a_atn_hold: assert property (p_atn_hold)
		else $error("atn held halt code wrong");

	property p_ext_done;
		@(posedge pclk) disable iff (!presetn)
		(report.valid && report.kind == SEQ_SEL_ATN &&
			report.outcome == OUT_DONE && extended_message_mode &&
			report.bytes_done == 2'h3) |=> sequence_step == STEP_6;
	endproperty
	a_ext_done: assert property (p_ext_done)
		else $error("extended completion step wrong");

	property p_ext_msg_parity;
		@(posedge pclk) disable iff (!presetn)
		(report.valid && report.kind == SEQ_SEL_ATN &&
			report.outcome == OUT_PARITY_MSG && extended_message_mode &&
			report.bytes_done >= MSG_TWO) |=>
			sequence_step == STEP_4 && interrupt_cause == 8'h02;
	endproperty
	a_ext_msg_parity: assert property (p_ext_msg_parity)
		else $error("late message parity code wrong");

	property p_recv;
		@(posedge pclk) disable iff (!presetn)
		(report.valid && report.kind == SEQ_RECV_CMD) |=>
			interrupt_cause[3] && sequence_step ==
			($past(report.outcome) == OUT_DONE ? STEP_2 : STEP_1);
	endproperty
	a_recv: assert property (p_recv)
		else $error("receive command code wrong");

	property p_disc_done;
		@(posedge pclk) disable iff (!presetn)
		(report.valid && report.kind == SEQ_DISCONNECT &&
			report.outcome == OUT_DONE) |=>
			sequence_step == STEP_2 && interrupt_cause == 8'h28;
	endproperty
	a_disc_done: assert property (p_disc_done)
		else $error("disconnect completion code wrong");

	property p_disc_atn;
		@(posedge pclk) disable iff (!presetn)
		(report.valid && report.kind == SEQ_DISCONNECT &&
			report.outcome == OUT_ATN_STOP) |=>
			interrupt_cause == (CAUSE_BUS_SERVICE | CAUSE_FUNC_DONE) &&
			sequence_step == ($past(report.bytes_done) >= MSG_TWO ?
			STEP_1 : STEP_0);
	endproperty
	a_disc_atn: assert property (p_disc_atn)
		else $error("disconnect atn halt code wrong");

	property p_term_atn;
		@(posedge pclk) disable iff (!presetn)
		(report.valid && report.kind == SEQ_TERMINATE &&
			report.outcome == OUT_ATN_STOP && report.bytes_done == MSG_ONE)
			|=> sequence_step == STEP_0 && interrupt_cause == 8'h18;
	endproperty
	a_term_atn: assert property (p_term_atn)
		else $error("terminate atn halt code wrong");

	property p_joint;
		@(posedge pclk) disable iff (!presetn)
		!report.valid |=> $stable(sequence_step) &&
			$stable(interrupt_cause);
	endproperty
	a_joint: assert property (p_joint)
		else $error("codes changed without a report");

endmodule

// *** sim/atn_initiator.sv ***
`timescale 1ns/1ns
module atn_initiator
#(
	parameter int LAG = 2
)
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// request from the bench
	input wire logic raise_atn,
	// scsi pin, idle high
	output logic scsi_atn_n
);
	logic [7:0] pipe;

	// slow initiator: atn follows the request after lag cycles
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pipe <= 8'h00;
		else
			pipe <= {pipe[6:0], raise_atn};
	end

	assign scsi_atn_n = !pipe[LAG-1];
endmodule

// *** sim/scsi_target_sequence_status_tb.sv ***
`timescale 1ns/1ns
module scsi_target_sequence_status_tb
	import scsi_seq_pkg::*;
;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic scsi_atn_n, seq_start, cmd_phase, raise_atn, err;
	logic fifo_push, report_done, extended_message_mode;
	logic [7:0] fifo_data;
	seq_report_s report;
	integer seed = 7837;
	int fails = 0;
	int checks_done = 0;

	scsi_target_sequence_status uut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .scsi_atn_n(scsi_atn_n),
		.seq_start(seq_start), .cmd_phase(cmd_phase), .report(report),
		.fifo_push(fifo_push), .fifo_data(fifo_data),
		.report_done(report_done),
		.extended_message_mode(extended_message_mode));

	atn_initiator #(.LAG(2)) peer (.pclk(pclk), .presetn(presetn),
		.raise_atn(raise_atn), .scsi_atn_n(scsi_atn_n));

	always #2 pclk = ~pclk;

	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			fails++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	function automatic logic [10:0] exp_res(input seq_kind_e k,
		input outcome_e o, input logic [1:0] b, input logic e, input logic a);
		logic [2:0] s;
		logic [7:0] c;
		logic late, hold;
		late = o == OUT_PARITY_MSG && e && b >= MSG_TWO;
		hold = o == OUT_ATN_HOLD;
		c = a ? CAUSE_BUS_SERVICE : 8'h00;
		s = (o == OUT_DONE) ? STEP_2 : (o == OUT_PARITY_CMD) ? STEP_1 : STEP_0;
		if (k >= SEQ_DISCONNECT && o != OUT_DONE)
			s = (b >= MSG_TWO) ? STEP_1 : STEP_0;
		if (k == SEQ_SEL_ATN && e && b == 2'h3)
			s = (o == OUT_DONE) ? STEP_6 : (o == OUT_PARITY_CMD) ? STEP_5 : s;
		case (k)
			SEQ_SEL_PLAIN: c = (s == STEP_0) ? CAUSE_SELECTED :
				c | CAUSE_SELECTED;
			SEQ_RECV_CMD: c = c | CAUSE_FUNC_DONE;
			SEQ_SEL_ATN:
			begin
				c = hold ? 8'h12 : late ? CAUSE_SEL_ATN : c | CAUSE_SEL_ATN;
				s = (late || (hold && e)) ? STEP_4 : s;
			end
			default: c = (o == OUT_DONE) ? 8'h28 : 8'h18;
		endcase
		return {s, c};
	endfunction

	task automatic run(input seq_kind_e k, input outcome_e o,
		input logic [1:0] b, input logic e);
		logic a;
		logic [7:0] id;
		logic [10:0] x;
		a = 1'($random(seed));
		id = 8'($random(seed));
		x = exp_res(k, o, b, e, a);
		apb(1'b1, ADDR_SEQ_CONTROL, {31'h0, e});
		check("mode", extended_message_mode, e);
		seq_start <= 1'b1;
		@(posedge pclk);
		seq_start <= 1'b0;
		cmd_phase <= 1'b1;
		raise_atn <= a;
		repeat (6) @(posedge pclk);
		// atn may drop after command phase; latched flag must remain
		cmd_phase <= 1'b0;
		raise_atn <= a & id[0];
		repeat (6) @(posedge pclk);
		report <= {1'b1, k, o, b, id};
		// release atn so the next command phase starts clean
		raise_atn <= 1'b0;
		@(posedge pclk);
		report <= '0;
		#1;
		check("done", report_done, 1'b1);
		@(posedge pclk);
		#1;
		check("push", fifo_push, o == OUT_HALT_SEL);
		if (o == OUT_HALT_SEL)
			check("bus id", fifo_data, id);
		@(posedge pclk);
		#1;
		if (o == OUT_HALT_SEL)
			check("null", fifo_data, NULL_MESSAGE);
		@(posedge pclk);
		apb(1'b0, ADDR_INTERRUPT_CAUSE, 32'h0);
		check("cause", q[7:0], x[7:0]);
		apb(1'b0, ADDR_SEQUENCE_STEP, 32'h0);
		check("step", q[2:0], x[10:8]);
	endtask

	initial
	begin
		#100000;
		fails++;
		end_of_test();
	end

	initial
	begin
		pclk = 1'b0;
		presetn = 1'b0;
		{psel, penable, pwrite, seq_start, cmd_phase, raise_atn} = 6'h00;
		paddr = 12'h000;
		pwdata = 32'h0;
		report = '0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, ADDR_INTERRUPT_CAUSE, 32'h0);
		check("cause reset", q[7:0], RESET_CAUSE);
		apb(1'b0, ADDR_SEQUENCE_STEP, 32'h0);
		check("step reset", q[2:0], RESET_STEP);
		check("mode reset", extended_message_mode, RESET_EXT_MSG);
		apb(1'b0, 12'h3FC, 32'h0);
		check("unmapped err", err, 1'b1);
		check("unmapped data", q, 32'h0);
		apb(1'b1, ADDR_INTERRUPT_CAUSE, 32'hFF);
		apb(1'b0, ADDR_INTERRUPT_CAUSE, 32'h0);
		check("cause ro", q[7:0], RESET_CAUSE);
		repeat (2)
		begin
			run(SEQ_SEL_PLAIN, OUT_DONE, 2'h0, 1'b0);
			run(SEQ_SEL_PLAIN, OUT_PARITY_CMD, 2'h0, 1'b0);
			run(SEQ_SEL_PLAIN, OUT_HALT_SEL, 2'h0, 1'b0);
			run(SEQ_SEL_ATN, OUT_DONE, MSG_ONE, 1'b0);
			run(SEQ_SEL_ATN, OUT_ATN_HOLD, MSG_ONE, 1'b0);
			run(SEQ_SEL_ATN, OUT_PARITY_MSG, MSG_ONE, 1'b0);
			run(SEQ_SEL_ATN, OUT_BAD_ID, MSG_ONE, 1'b1);
			run(SEQ_SEL_ATN, OUT_PARITY_CMD, MSG_ONE, 1'b0);
			run(SEQ_SEL_ATN, OUT_PARITY_CMD, 2'h3, 1'b1);
			run(SEQ_SEL_ATN, OUT_DONE, 2'h3, 1'b1);
			run(SEQ_SEL_ATN, OUT_ATN_HOLD, 2'h3, 1'b1);
			run(SEQ_SEL_ATN, OUT_PARITY_MSG, MSG_TWO, 1'b1);
			run(SEQ_SEL_ATN, OUT_DONE, MSG_ONE, 1'b1);
			run(SEQ_SEL_ATN, OUT_PARITY_CMD, MSG_ONE, 1'b1);
			run(SEQ_RECV_CMD, OUT_DONE, 2'h0, 1'b0);
			run(SEQ_RECV_CMD, OUT_PARITY_CMD, 2'h0, 1'b0);
			run(SEQ_DISCONNECT, OUT_DONE, MSG_TWO, 1'b0);
			run(SEQ_DISCONNECT, OUT_ATN_STOP, MSG_TWO, 1'b0);
			run(SEQ_DISCONNECT, OUT_ATN_STOP, MSG_ONE, 1'b0);
			run(SEQ_TERMINATE, OUT_DONE, MSG_TWO, 1'b0);
			run(SEQ_TERMINATE, OUT_ATN_STOP, MSG_TWO, 1'b0);
			run(SEQ_TERMINATE, OUT_ATN_STOP, MSG_ONE, 1'b0);
		end
		end_of_test();
	end
endmodule
